// ===== rtl/tioms_pkg.sv
// Shared constants for the timer I/O mode select block.
// Assumes a 32-bit AXI4-Lite register port and 16 timer channels.
package tioms_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int unsigned AW = 8;
   localparam logic [7:0] OFS_SEL_CH4_TO_7   = 8'h00;
   localparam logic [7:0] OFS_SEL_CH8_TO_11  = 8'h04;
   localparam logic [7:0] OFS_SEL_CH12_TO_15 = 8'h08;
   localparam logic [7:0] OFS_SOFT_START     = 8'h0C;
   localparam logic [7:0] OFS_STATUS         = 8'h10;

   // One-hot hit positions
   localparam int unsigned H_SEL0  = 0;
   localparam int unsigned H_SEL1  = 1;
   localparam int unsigned H_SEL2  = 2;
   localparam int unsigned H_START = 3;
   localparam int unsigned H_STAT  = 4;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int unsigned SEL_HI_LSB = 12;
   localparam int unsigned SEL_LO_LSB = 8;
   localparam logic [15:0] SEL_MASK   = 16'hFF00;
   localparam logic [15:0] SEL_RST    = 16'h0000;
   localparam int unsigned NPAIR      = 6;
   localparam int unsigned NCH        = 16;

   // Pair mode codes
   localparam logic [3:0] MODE_START_STOP    = 4'h4;
   localparam logic [3:0] MODE_SW_START_STOP = 4'h6;
   localparam logic [3:0] MODE_START_ONLY    = 4'h7;
   localparam logic [3:0] MODE_CHAIN_STOP    = 4'h8;
   localparam logic [3:0] MODE_LAST          = 4'h8;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;

   // Address decode, shared by write and read paths
   function automatic logic [4:0] tiomsHit(input logic [7:0] a);
      tiomsHit = 5'h0;
      tiomsHit[H_SEL0]  = (a == OFS_SEL_CH4_TO_7);
      tiomsHit[H_SEL1]  = (a == OFS_SEL_CH8_TO_11);
      tiomsHit[H_SEL2]  = (a == OFS_SEL_CH12_TO_15);
      tiomsHit[H_START] = (a == OFS_SOFT_START);
      tiomsHit[H_STAT]  = (a == OFS_STATUS);
   endfunction

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] tiomsMerge(input logic [15:0] old,
      input logic [15:0] dat, input logic [1:0] strb);
      tiomsMerge[7:0]  = strb[0] ? dat[7:0]  : old[7:0];
      tiomsMerge[15:8] = strb[1] ? dat[15:8] : old[15:8];
   endfunction

endpackage

// ===== rtl/tioms_pair_route.sv
// Routing of start and stop triggers for one even/odd channel pair.
// Assumes waveform inputs are synchronous; prev values come from flops.
`timescale 1ns/100ps
module tioms_pair_route import tioms_pkg::*; (
   input  wire logic [3:0] mode,
   input  wire logic       evenWave,
   input  wire logic       evenWavePrev,
   input  wire logic       lowWave,
   input  wire logic       lowWavePrev,
   output logic      [1:0] start,
   output logic      [1:0] stop,
   output logic            illegal
);
   logic evenRise;
   logic lowRise;

   // ----------------------------------------------------------------
   // Mode decode; bit 1 is the odd channel, bit 0 the even
   // ----------------------------------------------------------------
   always_comb begin
      evenRise = evenWave & ~evenWavePrev;
      lowRise  = lowWave & ~lowWavePrev;
      start    = 2'b00;
      stop     = 2'b11; // Held high: no falling edge, no stop
      illegal  = (mode > MODE_LAST);
      case (mode)
         MODE_START_STOP, MODE_SW_START_STOP: begin
            start = {evenRise, 1'b0};
            stop  = {evenWave, 1'b1};
         end
         MODE_START_ONLY: begin
            start = {evenRise, 1'b0};
         end
         MODE_CHAIN_STOP: begin
            start = {lowRise, lowRise};
            stop  = {lowWave, lowWave};
         end
         default: begin
            start = 2'b00;
         end
      endcase
   end
endmodule // tioms_pair_route

// ===== rtl/tioms_axil_slave.sv
// AXI4-Lite slave front end: one write and one read in flight.
// Assumes the register file answers writes and reads combinationally.
`timescale 1ns/100ps
module tioms_axil_slave import tioms_pkg::*; (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic [AW-1:0] s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [AW-1:0] s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   output logic               wrEn,
   output logic [AW-1:0]      wrAddr,
   output logic [31:0]        wrData,
   output logic [1:0]         wrStrb,
   input  wire logic          wrErr,
   input  wire logic [31:0]   rdData,
   input  wire logic          rdErr
);
   typedef struct packed {
      logic          awHeld;
      logic          wHeld;
      logic [AW-1:0] addr;
      logic [31:0]   data;
      logic [1:0]    strb;
      logic          awready;
      logic          wready;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          arready;
      logic          rvalid;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
   } tioms_axs_s;

   tioms_axs_s st_q;
   tioms_axs_s st_d;

   // Write fires once both halves are held and no response is pending
   assign wrEn   = st_q.awHeld & st_q.wHeld & ~st_q.bvalid;
   assign wrAddr = st_q.addr;
   assign wrData = st_q.data;
   assign wrStrb = st_q.strb;

   // ----------------------------------------------------------------
   // Channel handshakes
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      if (s_axi_awvalid && st_q.awready) begin
         st_d.awHeld  = 1'b1;
         st_d.awready = 1'b0;
         st_d.addr    = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_q.wready) begin
         st_d.wHeld  = 1'b1;
         st_d.wready = 1'b0;
         st_d.data   = s_axi_wdata;
         st_d.strb   = s_axi_wstrb[1:0];
      end
      if (wrEn) begin
         st_d.awHeld = 1'b0;
         st_d.wHeld  = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp  = wrErr ? RESP_DECERR : RESP_OKAY;
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid  = 1'b0;
         st_d.awready = 1'b1;
         st_d.wready  = 1'b1;
      end
      // Read data is sampled in the address cycle
      if (s_axi_arvalid && st_q.arready) begin
         st_d.arready = 1'b0;
         st_d.rvalid  = 1'b1;
         st_d.rdata   = rdErr ? 32'h0000_0000 : rdData;
         st_d.rresp   = rdErr ? RESP_DECERR : RESP_OKAY;
      end
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid  = 1'b0;
         st_d.arready = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q         <= '0;
         st_q.awready <= 1'b1;
         st_q.wready  <= 1'b1;
         st_q.arready <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign s_axi_awready = st_q.awready;
   assign s_axi_wready  = st_q.wready;
   assign s_axi_bvalid  = st_q.bvalid;
   assign s_axi_bresp   = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid  = st_q.rvalid;
   assign s_axi_rdata   = st_q.rdata;
   assign s_axi_rresp   = st_q.rresp;
endmodule // tioms_axil_slave

// ===== rtl/tioms_mode_select.sv
// Timer I/O mode select: pair mode registers, soft start, trigger routing.
// Assumes timers sample start pulses and stop levels on this clock.
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module tioms_mode_select import tioms_pkg::*; (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic [AW-1:0] s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [AW-1:0] s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   input  wire logic [15:0]   waveformOutput,
   output logic [15:0]        timerStart,
   output logic [15:0]        stopTriggerInput,
   output logic [23:0]        pairMode
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] sel0;
      logic [15:0] sel1;
      logic [15:0] sel2;
      logic [15:0] start;
      logic [15:0] stop;
      logic [15:0] wavePrev;
   } tioms_main_s;

   tioms_main_s st_q;
   tioms_main_s st_d;

   logic          wrEn;
   logic [AW-1:0] wrAddr;
   logic [31:0]   wrData;
   logic [1:0]    wrStrb;
   logic [4:0]    wrHit;
   logic [4:0]    rdHit;
   logic          wrErr;
   logic [31:0]   rdData;
   logic          rdErr;
   logic [15:0]   softBits;
   logic [23:0]   modes;
   logic [11:0]   pairStart;
   logic [11:0]   pairStop;
   logic [5:0]    illegal;

   // ----------------------------------------------------------------
   // Bus front end
   // ----------------------------------------------------------------
   tioms_axil_slave u_bus (
      .clk           (clk),
      .rst           (rst),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wrEn          (wrEn),
      .wrAddr        (wrAddr),
      .wrData        (wrData),
      .wrStrb        (wrStrb),
      .wrErr         (wrErr),
      .rdData        (rdData),
      .rdErr         (rdErr)
   );

   // Decode and read mux; start register reads as zero
   always_comb begin
      wrHit  = tiomsHit(wrAddr);
      rdHit  = tiomsHit(s_axi_araddr);
      wrErr  = (wrHit == 5'h0);
      rdErr  = (rdHit == 5'h0);
      rdData = 32'h0000_0000;
      if (rdHit[H_SEL0]) begin
         rdData[15:0] = st_q.sel0;
      end
      if (rdHit[H_SEL1]) begin
         rdData[15:0] = st_q.sel1;
      end
      if (rdHit[H_SEL2]) begin
         rdData[15:0] = st_q.sel2;
      end
      if (rdHit[H_STAT]) begin
         rdData[5:0] = illegal;
      end
   end

   // ----------------------------------------------------------------
   // Pair routing: pair k covers channels 4+2k and 5+2k
   // ----------------------------------------------------------------
   assign modes = {st_q.sel2[15:8], st_q.sel1[15:8], st_q.sel0[15:8]};

   for (genvar k = 0; k < NPAIR; k++) begin : g_pair
      // Mode 8 chains from the waveform of the pair below
      tioms_pair_route u_route (
         .mode         (modes[4*k +: 4]),
         .evenWave     (waveformOutput[4+2*k]),
         .evenWavePrev (st_q.wavePrev[4+2*k]),
         .lowWave      (waveformOutput[2+2*k]),
         .lowWavePrev  (st_q.wavePrev[2+2*k]),
         .start        (pairStart[2*k +: 2]),
         .stop         (pairStop[2*k +: 2]),
         .illegal      (illegal[k])
      );
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d          = st_q;
      st_d.wavePrev = waveformOutput;
      softBits      = 16'h0000;
      // Zeros and unwritten lanes leave channels alone
      if (wrEn && wrHit[H_START]) begin
         softBits = wrData[15:0] & {{8{wrStrb[1]}}, {8{wrStrb[0]}}};
      end
      if (wrEn && wrHit[H_SEL0]) begin
         st_d.sel0 = tiomsMerge(st_q.sel0, wrData[15:0], wrStrb) & SEL_MASK;
      end
      if (wrEn && wrHit[H_SEL1]) begin
         st_d.sel1 = tiomsMerge(st_q.sel1, wrData[15:0], wrStrb) & SEL_MASK;
      end
      if (wrEn && wrHit[H_SEL2]) begin
         st_d.sel2 = tiomsMerge(st_q.sel2, wrData[15:0], wrStrb) & SEL_MASK;
      end
      // Pulses last one cycle, all channels on the same edge
      st_d.start = softBits | {pairStart, 4'h0};
      st_d.stop  = {pairStop, 4'hF};
   end

   // Timer reset assumed during mode change, so no glitch filter here
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q.sel0     <= SEL_RST;
         st_q.sel1     <= SEL_RST;
         st_q.sel2     <= SEL_RST;
         st_q.start    <= 16'h0000;
         st_q.stop     <= 16'hFFFF;
         st_q.wavePrev <= 16'h0000;
      end else begin
         st_q <= st_d;
      end
   end

   assign timerStart       = st_q.start;
   assign stopTriggerInput = st_q.stop;
   assign pairMode         = modes;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_wrSel0;
      wrEn && wrHit[H_SEL0] && wrStrb[1];
   endsequence

   sequence s_softWr;
      wrEn && wrHit[H_START];
   endsequence

   sequence s_rise8;
      modes[11:8] == MODE_START_STOP && waveformOutput[8] && !st_q.wavePrev[8];
   endsequence

   property p_pair_mode_ch4_5;
      s_wrSel0 |=> st_q.sel0[11:8] == $past(wrData[11:8]);
   endproperty
   a_pair_mode_ch4_5: assert property (p_pair_mode_ch4_5)
      else $error("ch4/5 mode field did not take written value");

   property p_pair_mode_ch8_9;
      (wrEn && wrHit[H_SEL1] && wrStrb == 2'b11) |=>
         st_q.sel1 == ($past(wrData[15:0]) & SEL_MASK);
   endproperty
   a_pair_mode_ch8_9: assert property (p_pair_mode_ch8_9)
      else $error("ch8-11 select register mismatch after write");

   property p_pair_mode_ch12_13;
      (wrEn && wrHit[H_SEL2] && wrStrb == 2'b11) ##1 !wrEn |=>
         pairMode[23:16] == $past(wrData[15:8], 2);
   endproperty
   a_pair_mode_ch12_13: assert property (p_pair_mode_ch12_13)
      else $error("ch12-15 pair modes not driven from register");

   property p_lowModes;
      (modes[3:0] < MODE_START_STOP) [*2] |-> stopTriggerInput[5];
   endproperty
   a_lowModes: assert property (p_lowModes)
      else $error("stop trigger moved in a mode without chaining");

   property p_prohib;
      (st_q.sel0[11:8] > MODE_LAST) |-> ##1 (rdHit[H_STAT] -> rdData[0]);
   endproperty
   a_prohib: assert property (p_prohib)
      else $error("prohibited code not flagged in status");

   property p_softStart;
      s_softWr and (wrStrb == 2'b11) |=>
         (timerStart & $past(wrData[15:0])) == $past(wrData[15:0]);
   endproperty
   a_softStart: assert property (p_softStart)
      else $error("written start bits did not all pulse together");

   property p_zeroNoStart;
      timerStart[3:0] != 4'h0 |-> $past(wrEn && wrHit[H_START]);
   endproperty
   a_zeroNoStart: assert property (p_zeroNoStart)
      else $error("low channel start without a start write");

   property p_startReadZero;
      (s_axi_arvalid && s_axi_arready && rdHit[H_START]) |=>
         s_axi_rvalid && s_axi_rdata == 32'h0000_0000;
   endproperty
   a_startReadZero: assert property (p_startReadZero)
      else $error("start register read did not return zero");

   property p_pulseOne;
      (timerStart[0] && !(wrEn && wrHit[H_START])) |=> !timerStart[0];
   endproperty
   a_pulseOne: assert property (p_pulseOne)
      else $error("start pulse longer than one cycle");

   property p_mode4Start;
      s_rise8 |=> timerStart[9] && !timerStart[8] ##0 stopTriggerInput[9];
   endproperty
   a_mode4Start: assert property (p_mode4Start)
      else $error("odd channel not started on even rise in mode 4");

   property p_chainStop;
      (modes[3:0] == MODE_CHAIN_STOP) |=>
         stopTriggerInput[5:4] == {2{$past(waveformOutput[2])}};
   endproperty
   a_chainStop: assert property (p_chainStop)
      else $error("mode 8 stop trigger not following lower pair");

   // Mode 4 stop level is the even waveform, one edge late
   property p_mode4Stop;
      (modes[11:8] == MODE_START_STOP) |=>
         stopTriggerInput[9] == $past(waveformOutput[8]);
   endproperty
   a_mode4Stop: assert property (p_mode4Stop)
      else $error("mode 4 odd stop level not following even waveform");

   property p_chainStart;
      (modes[15:12] == MODE_CHAIN_STOP && waveformOutput[8] && !st_q.wavePrev[8]) |=>
         timerStart[11:10] == 2'b11;
   endproperty
   a_chainStart: assert property (p_chainStart)
      else $error("mode 8 pair not started on lower pair rise");

   // Channels 3:0 have no chained source, so any pulse there was written
   property p_softZero;
      (wrEn && wrHit[H_START] && wrStrb == 2'b11) |=>
         (timerStart[3:0] & ~$past(wrData[3:0])) == 4'h0;
   endproperty
   a_softZero: assert property (p_softZero)
      else $error("start pulse on a channel written with zero");

endmodule // tioms_mode_select

// ===== verification/tioms_timer_model.sv
// Behavioural model of the sixteen timer channels behind the mode select.
// Assumes start pulses and stop levels are synchronous to clk.
`timescale 1ns/100ps
module tioms_timer_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [15:0] timerStart,
   input  wire logic [15:0] stopTriggerInput,
   input  wire logic [15:0] fnReset,
   input  wire logic [15:0] waveCmd,
   output logic      [15:0] waveformOutput,
   output logic      [15:0] running
);
   logic [15:0] stopPrev_q;

   // Waveform is commanded by the bench; no counting is modelled
   assign waveformOutput = waveCmd;

   // Run state: start pulse sets, stop fall or reset function clears.
   // Edge select is fixed to rising, so only the pulse itself starts.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stopPrev_q <= 16'hFFFF;
         running    <= 16'h0000;
      end else begin
         stopPrev_q <= stopTriggerInput;
         running    <= (running | timerStart) & ~(stopPrev_q & ~stopTriggerInput)
                       & ~fnReset;
      end
   end
endmodule // tioms_timer_model

// ===== verification/tioms_mode_select_tb_top.sv
// Self-checking bench for the timer I/O mode select block.
// Assumes tioms_pkg is compiled first; drives AXI4-Lite as a single master.
`timescale 1ns/100ps
module tioms_mode_select_tb_top import tioms_pkg::*;;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [15:0] waveCmd, waveOut, timerStart, stopTrig, fnReset, running;
   logic [15:0] lastStart, runAcc, startExp, stopLow;
   logic [23:0] pairMode;
   logic [3:0]  code;
   int err_count, checked;
   logic [15:0] pat [4] = '{16'hA5C3, 16'h0000, 16'hFFFF, 16'h5AFF};
   logic [3:0]  pst [4] = '{4'h3, 4'h3, 4'h1, 4'h2};
   logic [3:0]  chm [4] = '{4'h0, MODE_START_STOP, MODE_SW_START_STOP, MODE_START_ONLY};

   tioms_mode_select tioms_mode_select_i (.clk(clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .waveformOutput(waveOut),
      .timerStart(timerStart), .stopTriggerInput(stopTrig), .pairMode(pairMode));

   tioms_timer_model tioms_timer_model_i (.clk(clk), .rst(rst), .timerStart(timerStart),
      .stopTriggerInput(stopTrig), .fnReset(fnReset), .waveCmd(waveCmd),
      .waveformOutput(waveOut), .running(running));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Bready stays high; start pulses are caught at the response edge
   task automatic axiWrite(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                           input logic [1:0] r);
      int n;
      awaddr <= a;
      wdata <= {16'h0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 100);
      lastStart = timerStart;
      if (n >= 100) begin
         err_count++;
         conclude();
      end
      check({30'h0, bresp}, {30'h0, r});
   endtask

   task automatic axiRead(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 100);
      if (n >= 100) begin
         err_count++;
         conclude();
      end
      check(rdata, d);
      check({30'h0, rresp}, {30'h0, r});
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wstrb, wdata} = '0;
      waveCmd = 16'h0000;
      fnReset = 16'hFFFF;
      err_count = 0;
      checked = 0;
      runAcc = 16'h0000;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset state, write-only start register reads zero
      check({8'h00, pairMode}, 32'h0000_0000);
      check({16'h0000, stopTrig}, 32'h0000_FFFF);
      for (int i = 0; i < 5; i++) axiRead(8'(4 * i), 32'h0000_0000, RESP_OKAY);
      $display("test reset done");
      // Codes 0 to 9 in every field; timers held in reset function meanwhile
      for (int c = 0; c < 10; c++) begin
         code = 4'(c);
         for (int r = 0; r < 3; r++) begin
            axiWrite(8'(4 * r), {code, code, 8'hFF}, 4'h3, RESP_OKAY);
            axiRead(8'(4 * r), {16'h0000, code, code, 8'h00}, RESP_OKAY);
         end
         check({8'h00, pairMode}, {8'h00, {6{code}}});
         axiRead(OFS_STATUS, (c > 8) ? 32'h0000_003F : 32'h0000_0000, RESP_OKAY);
      end
      axiWrite(OFS_SEL_CH8_TO_11, 16'h1200, 4'h1, RESP_OKAY);
      axiRead(OFS_SEL_CH8_TO_11, 32'h0000_9900, RESP_OKAY);
      axiWrite(8'h14, 16'hFFFF, 4'h3, RESP_DECERR);
      axiRead(8'h14, 32'h0000_0000, RESP_DECERR);
      $display("test select fields done");
      // Simultaneous start with all pairs in mode 5
      for (int r = 0; r < 3; r++) axiWrite(8'(4 * r), 16'h5500, 4'h3, RESP_OKAY);
      fnReset <= 16'h0000;
      foreach (pat[k]) begin
         startExp = {pat[k][15:8] & {8{pst[k][1]}}, pat[k][7:0] & {8{pst[k][0]}}};
         runAcc = runAcc | startExp;
         axiWrite(OFS_SOFT_START, pat[k], pst[k], RESP_OKAY);
         check({16'h0000, lastStart}, {16'h0000, startExp});
         #1 check({16'h0000, timerStart}, 32'h0000_0000);
         check({16'h0000, running}, {16'h0000, runAcc});
         @(posedge clk);
      end
      $display("test soft start done");
      // Chained pairs: ch8/9 in the mode under test, ch10/11 in mode 8
      foreach (chm[k]) begin
         startExp = (chm[k] != 4'h0) ? 16'h0E00 : 16'h0C00;
         stopLow = (chm[k] == MODE_START_ONLY || chm[k] == 4'h0) ? 16'h0C00 : 16'h0E00;
         fnReset <= 16'hFFFF;
         axiWrite(OFS_SEL_CH8_TO_11, {MODE_CHAIN_STOP, chm[k], 8'h00}, 4'h3, RESP_OKAY);
         fnReset <= 16'h0000;
         waveCmd[8] <= 1'b1;
         @(posedge clk);
         #1 check({16'h0000, timerStart}, {16'h0000, startExp});
         @(posedge clk);
         waveCmd[8] <= 1'b0;
         #1 check({16'h0000, timerStart}, 32'h0000_0000);
         @(posedge clk);
         #1 check({16'h0000, stopTrig}, {16'h0000, ~stopLow});
         @(posedge clk);
         #1 check({16'h0000, running & 16'h0E00}, {16'h0000, startExp & ~stopLow});
         @(posedge clk);
      end
      $display("test chained modes done");
      conclude();
   end
endmodule // tioms_mode_select_tb_top
